// [design/pmw_map.vh]
// constants and field layout for the pci master burst write path
// Function
// - While a burst is running as bus master, frame stays asserted across the data phases.
// - A data phase finishes on any cycle in which irdy and the two-cycle-late synchronized trdy are both asserted.
// - The cycle after a data phase finishes, the remaining burst count drops by one.
// - Once the target takes the current word, the next word and byte enables go onto ad and cbe.
// - If local ready, synchronized two cycles late, was asserted the previous cycle, irdy stays asserted this cycle.
// - If a data phase closed and local ready and trdy, synchronized two cycles late, were all asserted the previous cycle, the word-taken strobe is asserted.
`ifndef PMW_MAP_VH
`define PMW_MAP_VH
`define PMW_AD_W        32
`define PMW_BE_W        4
`define PMW_CNT_W       16
`define PMW_DEASSERT_N  1'b1
`define PMW_ASSERT_N    1'b0
`define PMW_CNT_ONE     16'h0001
`define PMW_CNT_ZERO    16'h0000
`define PMW_ON          1'b1
`define PMW_OFF         1'b0
`define PMW_ST_W        3
`define PMW_ST_IDLE     3'b001
`define PMW_ST_DATA     3'b010
`define PMW_ST_LAST     3'b100
`define PMW_N_PINS      2
`define PMW_PIN_TRDY    0
`define PMW_PIN_RDY     1
`endif

// [design/pmw_burst_write.v]
// pci master burst write data path: local words onto ad/cbe with irdy/trdy handshake
`timescale 1ns/10ps
`include "pmw_map.vh"
module pmw_burst_write #(
	parameter AD_W  = `PMW_AD_W,
	parameter BE_W  = `PMW_BE_W,
	parameter CNT_W = `PMW_CNT_W
) (
	input  wire             clock,                    // pci clock
	input  wire             rst,                      // async reset, active high
	input  wire             burst_start,              // one-cycle pulse: begin data phases
	input  wire [CNT_W-1:0] burst_length,             // words in the burst, sampled at start
	input  wire [AD_W-1:0]  local_write_data,         // word from local master
	input  wire [BE_W-1:0]  local_write_byte_enables, // byte enables from local master, active low
	input  wire             local_source_ready_n,     // local master has a word, active low
	input  wire             trdy_n_in,                // target ready pin, active low
	output reg  [AD_W-1:0]  ad_out,                   // ad pin value
	output reg              ad_oe,                    // ad/cbe driven while high
	output reg  [BE_W-1:0]  cbe_n_out,                // cbe pin value
	output reg              frame_n_out,              // frame pin value, active low
	output reg              frame_oe,                 // frame driven while high
	output reg              irdy_n_out,               // irdy pin value, active low
	output reg              irdy_oe,                  // irdy driven while high
	output reg              local_word_taken_n,       // word taken strobe, active low
	output reg  [CNT_W-1:0] local_burst_remaining,    // words still to complete
	output reg              burst_busy                // data phases in progress
);
	localparam [`PMW_ST_W-1:0] ST_IDLE  = `PMW_ST_IDLE;  // no burst, pins released
	localparam [`PMW_ST_W-1:0] ST_DATA  = `PMW_ST_DATA;  // data phases running
	localparam [`PMW_ST_W-1:0] ST_LAST  = `PMW_ST_LAST;  // final phase closed, count settles
	localparam [CNT_W-1:0]     CNT_ONE  = `PMW_CNT_ONE;
	localparam [CNT_W-1:0]     CNT_ZERO = `PMW_CNT_ZERO;
	localparam                 N_PINS   = `PMW_N_PINS;
	localparam                 PIN_TRDY = `PMW_PIN_TRDY;
	localparam                 PIN_RDY  = `PMW_PIN_RDY;

	// registered state
	reg  [`PMW_ST_W-1:0] state_ff;
	reg                  rdy_prev_n_ff;
	reg                  trdy_prev_n_ff;
	reg                  phase_done_ff;

	// next values
	reg  [`PMW_ST_W-1:0] nxt_state;
	reg                  nxt_rdy_prev_n;
	reg                  nxt_trdy_prev_n;
	reg                  nxt_phase_done;
	reg  [AD_W-1:0]      nxt_ad_out;
	reg                  nxt_ad_oe;
	reg  [BE_W-1:0]      nxt_cbe_n_out;
	reg                  nxt_frame_n_out;
	reg                  nxt_frame_oe;
	reg                  nxt_irdy_n_out;
	reg                  nxt_irdy_oe;
	reg                  nxt_local_word_taken_n;
	reg  [CNT_W-1:0]     nxt_local_burst_remaining;
	reg                  nxt_burst_busy;

	// decoded conditions
	wire [N_PINS-1:0]    pin_raw;
	wire [N_PINS-1:0]    pin_sync;
	wire                 trdy_sync_n;
	wire                 rdy_sync_n;
	wire                 in_data;
	wire                 start_ok;
	wire                 phase_done;
	wire [CNT_W-1:0]     rem_now;
	wire                 last_phase;

	assign pin_raw[PIN_TRDY] = trdy_n_in;
	assign pin_raw[PIN_RDY]  = local_source_ready_n;

	// both pins are foreign to this clock; only the second stage is read
	// costs two cycles of latency against the bus timing
	genvar g;
	generate
		for (g = 0; g < N_PINS; g = g + 1) begin : g_sync
			reg meta_ff;
			reg sync_ff;
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					meta_ff <= `PMW_DEASSERT_N;
					sync_ff <= `PMW_DEASSERT_N;
				end else begin
					meta_ff <= pin_raw[g];
					sync_ff <= meta_ff;
				end
			end
			assign pin_sync[g] = sync_ff;
		end
	endgenerate

	assign trdy_sync_n = pin_sync[PIN_TRDY];
	assign rdy_sync_n  = pin_sync[PIN_RDY];

	assign in_data    = (state_ff == ST_DATA);
	assign start_ok   = burst_start && (state_ff == ST_IDLE) && (burst_length != CNT_ZERO);
	assign phase_done = in_data && !irdy_n_out && !trdy_sync_n;
	// count still owes the decrement of a phase closed last cycle
	assign rem_now    = phase_done_ff ? (local_burst_remaining - CNT_ONE) : local_burst_remaining;
	assign last_phase = (rem_now == CNT_ONE);

	always @* begin
		nxt_state                 = state_ff;
		nxt_ad_out                = ad_out;
		nxt_ad_oe                 = ad_oe;
		nxt_cbe_n_out             = cbe_n_out;
		nxt_frame_n_out           = frame_n_out;
		nxt_frame_oe              = frame_oe;
		nxt_irdy_n_out            = irdy_n_out;
		nxt_irdy_oe               = irdy_oe;
		nxt_burst_busy            = burst_busy;
		nxt_rdy_prev_n            = rdy_sync_n;
		nxt_trdy_prev_n           = trdy_sync_n;
		nxt_phase_done            = phase_done;
		// strobe only for a phase that really closed: one strobe per word
		nxt_local_word_taken_n    = !(phase_done_ff && !rdy_prev_n_ff && !trdy_prev_n_ff);
		nxt_local_burst_remaining = rem_now;
		case (state_ff)
			ST_IDLE: begin
				if (start_ok) begin
					nxt_state                 = ST_DATA;
					nxt_burst_busy            = `PMW_ON;
					nxt_local_burst_remaining = burst_length;
					nxt_frame_n_out           = `PMW_ASSERT_N;
					nxt_frame_oe              = `PMW_ON;
					nxt_irdy_oe               = `PMW_ON;
					nxt_ad_oe                 = `PMW_ON;
					nxt_ad_out                = local_write_data;
					nxt_cbe_n_out             = local_write_byte_enables;
				end
			end
			ST_DATA: begin
				nxt_frame_n_out = `PMW_ASSERT_N;
				// local master drops ready after its last word and holds it while it has more
				nxt_irdy_n_out  = rdy_prev_n_ff;
				if (phase_done) begin
					if (last_phase) begin
						nxt_state       = ST_LAST;
						nxt_frame_n_out = `PMW_DEASSERT_N;
						nxt_irdy_n_out  = `PMW_DEASSERT_N;
					end else begin
						nxt_ad_out    = local_write_data;
						nxt_cbe_n_out = local_write_byte_enables;
					end
				end
			end
			ST_LAST: begin
				// count reaches zero on this edge; pins released with it
				nxt_state      = ST_IDLE;
				nxt_burst_busy = `PMW_OFF;
				nxt_frame_oe   = `PMW_OFF;
				nxt_irdy_oe    = `PMW_OFF;
				nxt_ad_oe      = `PMW_OFF;
				nxt_irdy_n_out = `PMW_DEASSERT_N;
			end
			default: begin
				nxt_state       = ST_IDLE;
				nxt_burst_busy  = `PMW_OFF;
				nxt_frame_n_out = `PMW_DEASSERT_N;
				nxt_frame_oe    = `PMW_OFF;
				nxt_irdy_n_out  = `PMW_DEASSERT_N;
				nxt_irdy_oe     = `PMW_OFF;
				nxt_ad_oe       = `PMW_OFF;
			end
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff              <= ST_IDLE;
			rdy_prev_n_ff         <= `PMW_DEASSERT_N;
			trdy_prev_n_ff        <= `PMW_DEASSERT_N;
			phase_done_ff         <= `PMW_OFF;
			ad_out                <= {AD_W{`PMW_OFF}};
			ad_oe                 <= `PMW_OFF;
			cbe_n_out             <= {BE_W{`PMW_DEASSERT_N}};
			frame_n_out           <= `PMW_DEASSERT_N;
			frame_oe              <= `PMW_OFF;
			irdy_n_out            <= `PMW_DEASSERT_N;
			irdy_oe               <= `PMW_OFF;
			local_word_taken_n    <= `PMW_DEASSERT_N;
			local_burst_remaining <= CNT_ZERO;
			burst_busy            <= `PMW_OFF;
		end else begin
			state_ff              <= nxt_state;
			rdy_prev_n_ff         <= nxt_rdy_prev_n;
			trdy_prev_n_ff        <= nxt_trdy_prev_n;
			phase_done_ff         <= nxt_phase_done;
			ad_out                <= nxt_ad_out;
			ad_oe                 <= nxt_ad_oe;
			cbe_n_out             <= nxt_cbe_n_out;
			frame_n_out           <= nxt_frame_n_out;
			frame_oe              <= nxt_frame_oe;
			irdy_n_out            <= nxt_irdy_n_out;
			irdy_oe               <= nxt_irdy_oe;
			local_word_taken_n    <= nxt_local_word_taken_n;
			local_burst_remaining <= nxt_local_burst_remaining;
			burst_busy            <= nxt_burst_busy;
		end
	end

	// limitation: a word is reloaded on the phase edge while its strobe comes
	// one cycle later, so a local master needs a one-cycle gap between phases
endmodule // pmw_burst_write

// [tb/pmw_chk.sv]
// assertions on the burst write path ports
`timescale 1ns/10ps
module pmw_chk(input wire clock, rst, frame_n_out, frame_oe, ad_oe, irdy_n_out, local_word_taken_n,
	burst_busy, local_source_ready_n, trdy_n_in, input wire [31:0] ad_out,
	input wire [15:0] local_burst_remaining);
default clocking @(posedge clock); endclocking
default disable iff (rst);
wire both_n = local_source_ready_n | trdy_n_in;
sequence last_s; local_burst_remaining == 16'h0001 ##1 !frame_oe && !ad_oe; endsequence
frame_hold_a: assert property (burst_busy && local_burst_remaining > 16'h0001 |-> !frame_n_out)
	else $error("frame released mid burst");
frame_end_a: assert property ($rose(frame_n_out) |-> last_s) else $error("bad burst end");
count_step_a: assert property ($past(burst_busy) && burst_busy && $changed(local_burst_remaining)
	|-> local_burst_remaining == $past(local_burst_remaining) - 16'h0001) else $error("count jump");
word_step_a: assert property (burst_busy && $past(burst_busy) && $changed(ad_out)
	|=> local_burst_remaining == $past(local_burst_remaining) - 16'h0001) else $error("ad moved");
irdy_follow_a: assert property (burst_busy && $fell(local_source_ready_n) |-> ##[1:4] !irdy_n_out)
	else $error("irdy not asserted");
taken_cause_a: assert property (!local_word_taken_n |-> !$past(both_n, 4))
	else $error("word taken without cause");
endmodule // pmw_chk

// [tb/pmw_tgt.sv]
// target model: takes a word on alternate cycles
`timescale 1ns/10ps
module pmw_tgt(input wire clock, irdy_oe, output logic trdy_n_in = 1'b1);
logic ph_ff = 1'b0;
always @(posedge clock) begin
	ph_ff <= #1 ~ph_ff;
	trdy_n_in <= #1 ~(irdy_oe & ph_ff); // idle pulled up
end
endmodule // pmw_tgt

// [tb/tb_top.sv]
// testbench for the burst write path
`timescale 1ns/10ps
module tb_top;
logic clock = 0, rst = 1, start = 0, rdy_n = 1;
logic [15:0] len = 0;
logic [31:0] dat = 0;
logic [3:0] be = 0;
wire [31:0] ad;
wire [3:0] cbe;
wire [15:0] rem;
wire fn, foe, aoe, irn, ioe, tk, busy, trn;
int n_mismatch = 0, checks_done = 0;
always #10 clock = ~clock;
pmw_burst_write pmw_burst_write_i(.clock, .rst, .burst_start(start), .burst_length(len),
	.local_write_data(dat), .local_write_byte_enables(be), .local_source_ready_n(rdy_n), .trdy_n_in(trn),
	.ad_out(ad), .ad_oe(aoe), .cbe_n_out(cbe), .frame_n_out(fn), .frame_oe(foe), .irdy_n_out(irn),
	.irdy_oe(ioe), .local_word_taken_n(tk), .local_burst_remaining(rem), .burst_busy(busy));
pmw_tgt pmw_tgt_i(.clock, .irdy_oe(ioe), .trdy_n_in(trn));
task cyc(int n); repeat (n) @(posedge clock); #1; endtask
task chk(input logic [63:0] s, e);
	checks_done++;
	if (s !== e) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, s, e); end
endtask
task conclude;
	$display("mismatches %0d checks %0d", n_mismatch, checks_done);
	if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask
task run_burst(input logic [15:0] n);
	int taken;
	taken = 0;
	len = n; dat = 32'h1234_5670 + n; be = n[3:0]; start = 1; cyc(1);
	chk({busy, fn, ad, cbe, rem}, {1'b1, 1'b0, 32'h1234_5670 + n, n[3:0], n});
	dat = dat + 32'h1; rdy_n = 0; len = 16'h0005; cyc(1); start = 0; // start while busy is ignored
	for (int i = 0; i < 200 && busy; i++) begin if (!tk) begin dat = dat + 32'h1; taken++; end cyc(1); end
	if (busy) begin n_mismatch++; conclude; end
	if (!tk) taken++;
	rdy_n = 1;
	chk({rem, fn, foe, ad}, {16'h0000, 1'b1, 1'b0, 32'h1234_5670 + n + n - 32'h1});
	chk(taken, n);
	cyc(2);
endtask
task reset_mid;
	len = 16'h0004; start = 1; rdy_n = 0; cyc(1); start = 0; cyc(3);
	rst = 1; cyc(1);
	chk({busy, fn, foe, aoe, ioe, irn, tk, rem}, {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000});
	rst = 0; rdy_n = 1; cyc(2);
	chk({busy, foe}, {1'b0, 1'b0});
endtask
task refuse_zero; len = 0; start = 1; cyc(1); start = 0; cyc(2); chk(busy, 1'b0); endtask
initial begin cyc(5); rst = 0; run_burst(16'h0003); run_burst(16'h0001); reset_mid; refuse_zero; conclude; end
endmodule // tb_top
bind pmw_burst_write pmw_chk pmw_chk_i(.clock, .rst, .frame_n_out, .frame_oe, .ad_oe, .irdy_n_out,
	.local_word_taken_n, .burst_busy, .local_source_ready_n, .trdy_n_in, .ad_out, .local_burst_remaining);
